// [mcap_pkg.sv]
package mcap_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_POSTBOOT_FILTER = 8'h5B;
  localparam logic [7:0] REG_FAULT_BEHAV     = 8'h5C;
  localparam logic [7:0] REG_ALERT_CFG       = 8'h5D;
  localparam logic [7:0] REG_VERSION         = 8'h5E;
  localparam logic [7:0] REG_LOCK            = 8'h5F;

  // ----------------------------------------------------------------
  // field positions, widths and writable masks
  // ----------------------------------------------------------------
  localparam int PB_TMO_LSB   = 0;
  localparam int PB_TMO_W     = 4;
  localparam int FILT_LSB     = 4;
  localparam int FILT_W       = 3;
  localparam int OC_TMO_LSB   = 0;
  localparam int OC_TMO_W     = 2;
  localparam int OC_LATCH_BIT = 2;
  localparam int HYST_BIT     = 5;
  localparam int CONSEC_BIT   = 6;
  localparam int LOG_ADC_BIT  = 7;
  localparam int CFG_LOCK_BIT = 0;
  localparam int LOG_LOCK_BIT = 1;
  localparam int ALERT_EN_BIT = 0;

  localparam logic [7:0] PB_MASK = 8'h7F;
  localparam logic [7:0] FB_MASK = 8'hE7;
  localparam logic [7:0] AC_MASK = 8'h01;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PB_RST  = 8'h00;
  localparam logic [7:0] FB_RST  = 8'h00;
  localparam logic [7:0] AC_RST  = 8'h01;
  localparam logic [7:0] VER_RST = 8'h00;

  // ----------------------------------------------------------------
  // bus addresses and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ARA_ADDR     = 7'h0C;
  localparam logic [7:0] CMD_REBOOT   = 8'hFC;
  localparam logic [7:0] CMD_SW_LOG   = 8'hFD;
  localparam logic [7:0] CMD_BLK_WR   = 8'hFA;
  localparam logic [7:0] CMD_BLK_RD   = 8'hFB;
  localparam logic [7:0] BLK_RD_COUNT = 8'h04;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 10_000_000;
  localparam int PB_UNIT_US       = 1000;
  localparam int PB_UNIT_CYC      = (CLK_HZ / 1_000_000) * PB_UNIT_US;

  // ----------------------------------------------------------------
  // serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_RX       = 7'b0001000,
    ST_RX_ACK   = 7'b0010000,
    ST_TX       = 7'b0100000,
    ST_TX_ACK   = 7'b1000000
  } mcap_state_t;

endpackage : mcap_pkg

// [mcap_twi_cond.sv]
`timescale 1ns/1ps
module mcap_twi_cond (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      start_det,
  output logic      stop_det,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      sda_bit
);

  logic scl_q;
  logic scl_qq;
  logic sda_q;
  logic sda_qq;
  logic next_scl_q;
  logic next_sda_q;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // two-stage history of both bus lines
  always_comb begin
    next_scl_q = scl_in;
    next_sda_q = sda_in;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q  <= 1'b1;
      scl_qq <= 1'b1;
      sda_q  <= 1'b1;
      sda_qq <= 1'b1;
    end else begin
      scl_q  <= next_scl_q;
      scl_qq <= scl_q;
      sda_q  <= next_sda_q;
      sda_qq <= sda_q;
    end
  end

  // ----------------------------------------------------------------
  // bus condition decode
  // ----------------------------------------------------------------
  // sda moving while scl high marks start or stop
  assign start_det = scl_q & scl_qq & sda_qq & ~sda_q;
  assign stop_det  = scl_q & scl_qq & ~sda_qq & sda_q;
  assign scl_rise  = scl_q & ~scl_qq;
  assign scl_fall  = ~scl_q & scl_qq;
  assign sda_bit   = sda_q;

endmodule : mcap_twi_cond

// [mcap_top.sv]
`timescale 1ns/1ps
module mcap_top
  import mcap_pkg::*;
#(
  parameter int PB_UNIT_CYCLES = PB_UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            alert_out,
  output logic            alert_oe_n,
  input  wire logic [6:0] slave_addr,
  input  wire logic       aux_fault_out_a_n,
  input  wire logic       aux_fault_out_b_n,
  input  wire logic       reset_out_n,
  input  wire logic       overtemp_out_n,
  input  wire logic [1:0] gpio_fault_n,
  input  wire logic [1:0] gpio_is_fault,
  input  wire logic       overcurrent_cond,
  output logic            overcurrent_out_n,
  input  wire logic       fault_log_trig,
  output logic            fault_log_store,
  output logic            log_adc_results,
  output logic            boot_start,
  output logic            postboot_mask,
  output logic [3:0]      postboot_tmo,
  output logic [2:0]      filter_cutoff,
  output logic [1:0]      oc_timeout,
  output logic            hyst_large,
  output logic            consec_fault
);

  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  logic        sda_bit;
  mcap_state_t state;
  mcap_state_t next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic        sda_pull;
  logic        next_sda_pull;
  logic        is_read;
  logic        next_is_read;
  logic        ara_sel;
  logic        next_ara_sel;
  logic        cnt_pend;
  logic        next_cnt_pend;
  logic [1:0]  byte_idx;
  logic [1:0]  next_byte_idx;
  logic [7:0]  cmd;
  logic [7:0]  next_cmd;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic [7:0]  blk_left;
  logic [7:0]  next_blk_left;
  logic [7:0]  reg_pbf;
  logic [7:0]  next_reg_pbf;
  logic [7:0]  reg_fb;
  logic [7:0]  next_reg_fb;
  logic [7:0]  reg_acfg;
  logic [7:0]  next_reg_acfg;
  logic [7:0]  reg_ver;
  logic [7:0]  next_reg_ver;
  logic        cfg_lock;
  logic        next_cfg_lock;
  logic        log_lock;
  logic        next_log_lock;
  logic        reboot_req;
  logic        next_reboot_req;
  logic        swlog_req;
  logic        next_swlog_req;
  logic        log_clear;
  logic        log_trig;
  logic        wr_en;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [7:0]  tx_byte;
  logic        addr_hit;
  logic        ara_hit;
  logic        alert_out_active;

  // ----------------------------------------------------------------
  // bus condition detector
  // ----------------------------------------------------------------
  mcap_twi_cond u_cond (
    .clk       (clk),
    .arst_n    (arst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .start_det (start_det),
    .stop_det  (stop_det),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .sda_bit   (sda_bit)
  );

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // unused bits zero
  always_comb begin
    case (ptr)
      REG_POSTBOOT_FILTER: rd_data = reg_pbf;
      REG_FAULT_BEHAV:     rd_data = reg_fb;
      REG_ALERT_CFG:       rd_data = reg_acfg;
      REG_VERSION:         rd_data = reg_ver;
      REG_LOCK:            rd_data = {6'h00, log_lock, cfg_lock};
      default:             rd_data = 8'h00;
    endcase
  end

  assign tx_byte  = ara_sel ? {slave_addr, 1'b0} : (cnt_pend ? BLK_RD_COUNT : rd_data);
  assign addr_hit = (shreg[7:1] == slave_addr);
  assign ara_hit  = (shreg[7:1] == ARA_ADDR) && alert_out_active;

  assign alert_out_active = ~alert_oe_n;

  // ----------------------------------------------------------------
  // serial engine and register file
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_sda_pull   = sda_pull;
    next_is_read    = is_read;
    next_ara_sel    = ara_sel;
    next_cnt_pend   = cnt_pend;
    next_byte_idx   = byte_idx;
    next_cmd        = cmd;
    next_ptr        = ptr;
    next_blk_left   = blk_left;
    next_reboot_req = 1'b0;
    next_swlog_req  = 1'b0;
    wr_en           = 1'b0;
    wr_data         = shreg;
    if (stop_det) begin
      if (!is_read && state != ST_IDLE && byte_idx == 2'd1) begin
        next_reboot_req = (cmd == CMD_REBOOT);
        next_swlog_req  = (cmd == CMD_SW_LOG);
      end
      next_state    = ST_IDLE;
      next_sda_pull = 1'b0;
    end else if (start_det) begin
      next_state    = ST_ADDR;
      next_bit_cnt  = 4'h0;
      next_byte_idx = 2'd0;
      next_sda_pull = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda_bit};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
          end
          if (scl_fall && bit_cnt == 4'h8 && state == ST_ADDR) begin
            if (addr_hit || ara_hit) begin
              next_sda_pull = 1'b1;
              next_is_read  = shreg[0];
              next_ara_sel  = ~addr_hit;
              next_cnt_pend = shreg[0] && addr_hit && (cmd == CMD_BLK_RD);
              next_state    = ST_ADDR_ACK;
            end else begin
              next_state = ST_IDLE;
            end
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_sda_pull = 1'b1;
            next_state    = ST_RX_ACK;
            next_byte_idx = (byte_idx == 2'd2) ? 2'd2 : 2'(byte_idx + 2'd1);
            if (byte_idx == 2'd0) begin
              next_cmd = shreg;
              if (shreg < CMD_BLK_WR) begin
                next_ptr = shreg;
              end
            end else if (cmd == CMD_BLK_WR && byte_idx == 2'd1) begin
              next_blk_left = shreg;
            end else if (cmd != CMD_BLK_WR || blk_left != 8'h00) begin
              wr_en    = 1'b1;
              next_ptr = 8'(ptr + 8'h01);
              if (cmd == CMD_BLK_WR) begin
                next_blk_left = 8'(blk_left - 8'h01);
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (is_read) begin
              next_shreg    = tx_byte;
              next_sda_pull = ~tx_byte[7];
              next_bit_cnt  = 4'h1;
              next_state    = ST_TX;
              // pointer steps past each data byte once loaded
              if (!ara_sel && !cnt_pend) begin
                next_ptr = 8'(ptr + 8'h01);
              end
            end else begin
              next_sda_pull = 1'b0;
              next_bit_cnt  = 4'h0;
              next_state    = ST_RX;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            next_sda_pull = 1'b0;
            next_bit_cnt  = 4'h0;
            next_state    = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall && bit_cnt == 4'h8) begin
            next_sda_pull = 1'b0;
            next_state    = ST_TX_ACK;
          end else if (scl_fall) begin
            next_shreg    = {shreg[6:0], 1'b0};
            next_sda_pull = ~shreg[6];
            next_bit_cnt  = 4'(bit_cnt + 4'h1);
          end
        end
        ST_TX_ACK: begin
          if (scl_rise && sda_bit) begin
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            // successive pointer locations, or the address again for an alert reply
            // count byte is followed by the byte at the pointer
            next_cnt_pend = 1'b0;
            next_shreg    = cnt_pend ? rd_data : tx_byte;
            next_sda_pull = cnt_pend ? ~rd_data[7] : ~tx_byte[7];
            if (!ara_sel) begin
              next_ptr = 8'(ptr + 8'h01);
            end
            next_bit_cnt = 4'h1;
            next_state   = ST_TX;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register updates and lock flags
  // ----------------------------------------------------------------
  always_comb begin
    next_reg_pbf  = reg_pbf;
    next_reg_fb   = reg_fb;
    next_reg_acfg = reg_acfg;
    next_reg_ver  = reg_ver;
    next_cfg_lock = cfg_lock;
    log_clear     = 1'b0;
    if (wr_en && (!cfg_lock || ptr == REG_LOCK)) begin
      case (ptr)
        REG_POSTBOOT_FILTER: next_reg_pbf = wr_data & PB_MASK;
        REG_FAULT_BEHAV:     next_reg_fb = wr_data & FB_MASK;
        REG_ALERT_CFG:       next_reg_acfg = wr_data & AC_MASK;
        REG_VERSION:         next_reg_ver = wr_data;
        REG_LOCK: begin
          next_cfg_lock = cfg_lock ^ wr_data[CFG_LOCK_BIT];
          log_clear = wr_data[LOG_LOCK_BIT];
        end
        default: begin
          next_cfg_lock = cfg_lock;
        end
      endcase
    end
    log_trig      = fault_log_trig | swlog_req;
    next_log_lock = (log_lock & ~log_clear) | log_trig;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      sda_pull   <= 1'b0;
      is_read    <= 1'b0;
      ara_sel    <= 1'b0;
      cnt_pend   <= 1'b0;
      byte_idx   <= 2'd0;
      cmd        <= 8'h00;
      ptr        <= 8'h00;
      blk_left   <= 8'h00;
      reg_pbf    <= PB_RST;
      reg_fb     <= FB_RST;
      reg_acfg   <= AC_RST;
      reg_ver    <= VER_RST;
      cfg_lock   <= 1'b0;
      log_lock   <= 1'b0;
      reboot_req <= 1'b0;
      swlog_req  <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      sda_pull   <= next_sda_pull;
      is_read    <= next_is_read;
      ara_sel    <= next_ara_sel;
      cnt_pend   <= next_cnt_pend;
      byte_idx   <= next_byte_idx;
      cmd        <= next_cmd;
      ptr        <= next_ptr;
      blk_left   <= next_blk_left;
      reg_pbf    <= next_reg_pbf;
      reg_fb     <= next_reg_fb;
      reg_acfg   <= next_reg_acfg;
      reg_ver    <= next_reg_ver;
      cfg_lock   <= next_cfg_lock;
      log_lock   <= next_log_lock;
      reboot_req <= next_reboot_req;
      swlog_req  <= next_swlog_req;
    end
  end

  // ----------------------------------------------------------------
  // postboot timer, overcurrent latch and alert
  // ----------------------------------------------------------------
  logic        booted;
  logic        pb_active;
  logic        next_pb_active;
  logic [31:0] unit_cnt;
  logic [31:0] next_unit_cnt;
  logic [15:0] unit_tot;
  logic [15:0] next_unit_tot;
  logic [15:0] unit_lim;
  logic        boot_go;
  logic        oc_hold;
  logic        next_oc_hold;
  logic        oc_active;
  logic [1:0]  gpio_hit;
  logic        fault_any;
  logic        next_alert;
  logic        next_log_store;

  for (genvar g = 0; g < 2; g++) begin : g_gpio
    assign gpio_hit[g] = gpio_is_fault[g] & ~gpio_fault_n[g];
  end

  assign boot_go  = ~booted | reboot_req;
  assign unit_lim = 16'h0001 << (reg_pbf[PB_TMO_LSB +: PB_TMO_W] - 4'h1);

  always_comb begin
    next_pb_active = pb_active;
    next_unit_cnt  = unit_cnt;
    next_unit_tot  = unit_tot;
    if (boot_go) begin
      next_pb_active = (reg_pbf[PB_TMO_LSB +: PB_TMO_W] != 4'h0);
      next_unit_cnt  = 32'h0;
      next_unit_tot  = 16'h0;
    end else if (pb_active) begin
      next_unit_cnt = 32'(unit_cnt + 32'h1);
      if (unit_cnt == 32'(PB_UNIT_CYCLES - 1)) begin
        next_unit_cnt = 32'h0;
        next_unit_tot = 16'(unit_tot + 16'h1);
        if (unit_tot == 16'(unit_lim - 16'h1)) begin
          next_pb_active = 1'b0;
        end
      end
    end
    next_oc_hold = reg_fb[OC_LATCH_BIT] & ~boot_go & (oc_hold | overcurrent_cond);
    oc_active    = (overcurrent_cond | oc_hold) & ~pb_active;
    fault_any = ~aux_fault_out_a_n | ~aux_fault_out_b_n | ~reset_out_n | ~overtemp_out_n
              | oc_active | (|gpio_hit);
    next_alert = reg_acfg[ALERT_EN_BIT] & fault_any & ~pb_active;
    next_log_store = log_trig & ~log_lock;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      booted            <= 1'b0;
      pb_active         <= 1'b0;
      unit_cnt          <= 32'h0;
      unit_tot          <= 16'h0;
      oc_hold           <= 1'b0;
      overcurrent_out_n <= 1'b1;
      alert_oe_n        <= 1'b1;
      alert_out         <= 1'b0;
      sda_oe_n          <= 1'b1;
      sda_out           <= 1'b0;
      fault_log_store   <= 1'b0;
      boot_start        <= 1'b0;
    end else begin
      booted            <= 1'b1;
      pb_active         <= next_pb_active;
      unit_cnt          <= next_unit_cnt;
      unit_tot          <= next_unit_tot;
      oc_hold           <= next_oc_hold;
      overcurrent_out_n <= ~oc_active;
      alert_oe_n        <= ~next_alert;
      alert_out         <= 1'b0;
      sda_oe_n          <= ~next_sda_pull;
      sda_out           <= 1'b0;
      fault_log_store   <= next_log_store;
      boot_start        <= boot_go;
    end
  end

  // ----------------------------------------------------------------
  // configuration field outputs
  // ----------------------------------------------------------------
  // fields steer outside logic
  assign postboot_mask   = pb_active;
  assign postboot_tmo    = reg_pbf[PB_TMO_LSB +: PB_TMO_W];
  assign filter_cutoff   = reg_pbf[FILT_LSB +: FILT_W];
  assign oc_timeout      = reg_fb[OC_TMO_LSB +: OC_TMO_W];
  assign hyst_large      = reg_fb[HYST_BIT];
  assign consec_fault    = reg_fb[CONSEC_BIT];
  assign log_adc_results = reg_fb[LOG_ADC_BIT];

endmodule : mcap_top

// [mcap_props.sv]
`timescale 1ns/1ps
// ----
// checker for alert and bus pins
// ----
module mcap_props (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       alert_out,
  input wire logic       alert_oe_n,
  input wire logic       aux_fault_out_a_n,
  input wire logic       aux_fault_out_b_n,
  input wire logic       reset_out_n,
  input wire logic       overtemp_out_n,
  input wire logic [1:0] gpio_fault_n,
  input wire logic [1:0] gpio_is_fault,
  input wire logic       overcurrent_cond,
  input wire logic       overcurrent_out_n,
  input wire logic       fault_log_store,
  input wire logic       boot_start,
  input wire logic       postboot_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // no fault source is active
  wire quiet = aux_fault_out_a_n & aux_fault_out_b_n & reset_out_n & overtemp_out_n
    & overcurrent_out_n & ~overcurrent_cond & ~|(~gpio_fault_n & gpio_is_fault);
  a_alert_has_cause: assert property ($fell(alert_oe_n) |-> !$past(quiet))
    else $error("alert asserted without a fault");
  a_alert_release: assert property (quiet [*2] |=> alert_oe_n)
    else $error("alert held with no fault");
  a_mask_quiets: assert property (postboot_mask [*3] |-> alert_oe_n && overcurrent_out_n)
    else $error("output active during postboot");
  a_oc_has_cause: assert property ($fell(overcurrent_out_n)
    |-> $past(overcurrent_cond) || $past(overcurrent_cond, 2))
    else $error("overcurrent output without condition");
  a_boot_pulse: assert property (boot_start |=> !boot_start)
    else $error("boot strobe too long");
  a_log_pulse: assert property (fault_log_store |=> !fault_log_store)
    else $error("log strobe too long");
  // data moves only with clock low
  a_sda_low_scl: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data changed with clock high");
  a_pins_pull_only: assert property (!sda_out && !alert_out)
    else $error("pin drives high");
  c_log: cover property (fault_log_store);
  c_alert: cover property ($fell(alert_oe_n));
  c_latch: cover property (!overcurrent_out_n && !overcurrent_cond);
endmodule : mcap_props
bind mcap_top mcap_props u_props (.*);

// [mcap_mst.sv]
`timescale 1ns/1ps
// ----
// two-wire bus master
// ----
module mcap_mst (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  // lines start released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // one bus phase of five clocks
  task automatic ph(input logic c, input logic d);
    scl <= c;
    sda_drv <= d;
    repeat (5) @(posedge clk);
  endtask : ph
  task automatic st();
    ph(1'b0, sda_drv);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask : st
  task automatic sp();
    ph(1'b0, sda_drv);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask : sp
  // byte msb first, sampled at end of scl high, then ack slot
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic k);
    logic [8:0] w;
    w = {d, a};
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, sda_drv);
      ph(1'b0, w[i]);
      ph(1'b1, w[i]);
      {q, k} = {q[6:0], k, sda};
    end
  endtask : xbyte
endmodule : mcap_mst

// [tb.sv]
`timescale 1ns/1ps
// ----
// register, alert and fault tests
// ----
module tb;
  import mcap_pkg::*;
  localparam logic [6:0] SA = 7'h2A;
  logic       clk;
  logic       arst_n;
  logic       oc;
  logic       trig;
  logic [3:0] fn_n;
  logic [1:0] gfn_n;
  logic [1:0] gie;
  logic [7:0] q;
  logic       k;
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] br [5] = '{BLK_RD_COUNT, 8'h03, 8'h00, 8'h01, 8'h3C};
  int         checks = 0;
  int         miscompares = 0;
  int         nst = 0;
  int         nbt = 0;
  wire        scl, sda_drv, sda_out, sda_oe_n, alert_out, alert_oe_n;
  wire        oc_n, fls, bst, pbm, hyl, csf, lar;
  wire  [3:0] pbt;
  wire  [2:0] flc;
  wire  [1:0] oct;
  // open-drain data line with pull-up
  wire        sda = sda_drv & (sda_oe_n | sda_out);
  mcap_top #(.PB_UNIT_CYCLES(4)) u_dut (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n), .slave_addr(SA),
    .aux_fault_out_a_n(fn_n[0]), .aux_fault_out_b_n(fn_n[1]), .reset_out_n(fn_n[2]),
    .overtemp_out_n(fn_n[3]), .gpio_fault_n(gfn_n), .gpio_is_fault(gie),
    .overcurrent_cond(oc), .overcurrent_out_n(oc_n), .fault_log_trig(trig),
    .fault_log_store(fls), .log_adc_results(lar), .boot_start(bst), .postboot_mask(pbm),
    .postboot_tmo(pbt), .filter_cutoff(flc), .oc_timeout(oct), .hyst_large(hyl),
    .consec_fault(csf));
  mcap_mst u_m (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  // clock and strobe counters
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    nst <= nst + int'(fls === 1'b1);
    nbt <= nbt + int'(bst === 1'b1);
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic ac(input string n, input logic e);
    repeat (4) @(posedge clk);
    chk(n, {7'h0, alert_oe_n}, {7'h0, e});
  endtask : ac
  task automatic ob(input logic [7:0] d);
    u_m.xbyte(d, 1'b1, q, k);
  endtask : ob
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    u_m.st();
    ob({SA, 1'b0});
    ob(r);
    ob(d);
    u_m.sp();
  endtask : wr
  task automatic rd(input logic [7:0] r);
    u_m.st();
    ob({SA, 1'b0});
    ob(r);
    u_m.st();
    ob({SA, 1'b1});
    ob(8'hFF);
    u_m.sp();
  endtask : rd
  task automatic snd(input logic [7:0] c);
    u_m.st();
    ob({SA, 1'b0});
    ob(c);
    u_m.sp();
  endtask : snd
  // main sequence
  initial begin
    arst_n = 1'b0;
    oc = 1'b0;
    trig = 1'b0;
    fn_n = 4'hF;
    gfn_n = 2'h3;
    gie = 2'h0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rd(8'h5B + 8'(i));
      chk("reset value", q, rv[i]);
    end
    wr(REG_POSTBOOT_FILTER, 8'hFF);
    wr(REG_FAULT_BEHAV, 8'hFF);
    wr(REG_VERSION, 8'hA5);
    rd(REG_POSTBOOT_FILTER);
    chk("postboot reg", q, 8'h7F);
    rd(REG_FAULT_BEHAV);
    chk("behaviour reg", q, 8'hE7);
    chk("postboot fields", {1'b0, flc, pbt}, 8'h7F);
    chk("behaviour fields", {lar, csf, hyl, 3'h0, oct}, 8'hE3);
    wr(REG_POSTBOOT_FILTER, 8'h03);
    wr(REG_FAULT_BEHAV, 8'h00);
    snd(REG_VERSION);
    u_m.st();
    ob({SA, 1'b1});
    ob(8'hFF);
    u_m.sp();
    chk("receive byte", q, 8'hA5);
    snd(REG_VERSION);
    u_m.st();
    ob({SA, 1'b0});
    ob(CMD_BLK_WR);
    ob(8'h01);
    ob(8'h3C);
    u_m.sp();
    snd(REG_POSTBOOT_FILTER);
    u_m.st();
    ob({SA, 1'b0});
    ob(CMD_BLK_RD);
    u_m.st();
    ob({SA, 1'b1});
    for (int i = 0; i < 5; i++) begin
      u_m.xbyte(8'hFF, 1'(i == 4), q, k);
      chk("block read", q, br[i]);
    end
    u_m.sp();
    $display("test registers finished");
    wr(REG_LOCK, 8'h01);
    rd(REG_LOCK);
    chk("lock set", q, 8'h01);
    wr(REG_VERSION, 8'h77);
    rd(REG_VERSION);
    chk("locked write", q, 8'h3C);
    wr(REG_LOCK, 8'h01);
    rd(REG_LOCK);
    chk("lock toggled", q, 8'h00);
    for (int i = 0; i < 2; i++) begin
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (6) @(posedge clk);
      chk("log stores", 8'(nst), 8'h01);
    end
    rd(REG_LOCK);
    chk("log flag", q, 8'h02);
    wr(REG_LOCK, 8'h02);
    rd(REG_LOCK);
    chk("log rearm", q, 8'h00);
    snd(CMD_SW_LOG);
    chk("soft log", 8'(nst), 8'h02);
    wr(REG_LOCK, 8'h02);
    $display("test locks finished");
    for (int i = 0; i < 4; i++) begin
      fn_n <= ~(4'h1 << i);
      ac("fault alert", 1'b0);
      fn_n <= 4'hF;
      ac("alert release", 1'b1);
    end
    gie <= 2'h2;
    gfn_n <= 2'h2;
    ac("unconfigured pin", 1'b1);
    gfn_n <= 2'h1;
    ac("fault pin", 1'b0);
    u_m.st();
    ob({ARA_ADDR, 1'b1});
    chk("alert addr ack", {7'h0, k}, 8'h00);
    ob(8'hFF);
    u_m.sp();
    chk("alert reply", q, {SA, 1'b0});
    gfn_n <= 2'h3;
    ac("pin release", 1'b1);
    u_m.st();
    ob({ARA_ADDR, 1'b0});
    u_m.sp();
    chk("alert addr idle", {7'h0, k}, 8'h01);
    wr(REG_ALERT_CFG, 8'h00);
    fn_n <= 4'hE;
    ac("alert disabled", 1'b1);
    fn_n <= 4'hF;
    wr(REG_ALERT_CFG, 8'h01);
    $display("test alert finished");
    oc <= 1'b1;
    repeat (4) @(posedge clk);
    chk("oc follow", {7'h0, oc_n}, 8'h00);
    oc <= 1'b0;
    repeat (4) @(posedge clk);
    chk("oc clear", {7'h0, oc_n}, 8'h01);
    wr(REG_FAULT_BEHAV, 8'h04);
    oc <= 1'b1;
    repeat (3) @(posedge clk);
    oc <= 1'b0;
    repeat (4) @(posedge clk);
    chk("oc latched", {7'h0, oc_n}, 8'h00);
    snd(CMD_REBOOT);
    chk("boot strobes", 8'(nbt), 8'h02);
    chk("latch cleared", {7'h0, oc_n}, 8'h01);
    chk("postboot mask", {7'h0, pbm}, 8'h01);
    fn_n <= 4'hE;
    ac("masked alert", 1'b1);
    repeat (20) @(posedge clk);
    chk("mask over", {7'h0, alert_oe_n}, 8'h00);
    fn_n <= 4'hF;
    $display("test overcurrent finished");
    report_and_stop();
  end
endmodule : tb
